/* rtl/asop_pkg.sv */
// Purpose: Shared constants for the area status output pulser.
// Assumes: One 25 MHz clock; a 100 ms tick is derived from it.
// Notes: Output indices select bits of the output vector.
`default_nettype none
package asop_pkg;
  localparam int ASOP_CLK_HZ = 25000000;
  localparam int ASOP_TICK_MS = 100;
  localparam int ASOP_TICK_CYCLES = ASOP_CLK_HZ / 1000 * ASOP_TICK_MS;
  localparam int ASOP_NUM_OUT = 12;
  localparam int ASOP_TIME_W = 8;
  localparam int ASOP_TIME_MAX = 255;
  localparam int ASOP_O_BELL = 0;
  localparam int ASOP_O_EXIT = 1;
  localparam int ASOP_O_ENTRY = 2;
  localparam int ASOP_O_DISARMED = 3;
  localparam int ASOP_O_ARMED = 4;
  localparam int ASOP_O_BYPASS = 5;
  localparam int ASOP_O_TAMPER = 6;
  localparam int ASOP_O_MEMORY = 7;
  localparam int ASOP_O_COUNT = 8;
  localparam int ASOP_O_DEFER = 9;
  localparam int ASOP_O_FAIL = 10;
  localparam int ASOP_O_READY = 11;
  localparam logic [11:0] ASOP_ACT_RST = 12'h008;
  localparam logic [7:0] ASOP_TIME_RST = 8'h00;
  typedef enum logic [1:0] {
    ASOP_PH_ON = 2'h1,
    ASOP_PH_OFF = 2'h2
  } asop_phase_t;
endpackage
`default_nettype wire

/* rtl/asop_pulser.sv */
// Purpose: Area indication outputs set and cleared by area events, each cadenced on/off.
// Assumes: Events are one-cycle pulses from logic on core_clk; levels are synchronous.
// Notes: The pulse cadence tick runs every 100 ms; TICK_CYCLES may be shortened.
// Overview of operation
// - Bell turns on at area alarm only when the causing input has bell enabled.
// - Bell turns off when bell timer expires or the area is disarmed.
// - Pulsed active output: on time, off time, repeat, both in 100 ms units.
// - A zero on or off time makes an active output steady on.
// - On and off times are unsigned values from 0 to 255 units.
// - Exit output starts with exit delay; ends on armed, alarm, or disarm.
// - Entry output starts with entry delay; ends on disarm or alarm.
// - Disarmed output sets when disarming completes, clears when arming completes.
// - Armed output sets when arming completes, clears when disarming completes.
// - Bypass output on while any input is bypassed; clears on disarm complete.
// - Tamper output sets on tamper alarm; clears only on 24HR part disarm.
// - Alarm memory latches on any alarm until disarming completes.
// - Count output sets at count zero or maximum; clearing follows counting option.
// - Defer output sets at defer warning; clears on arming start or cancel.
// - Fail-to-arm output sets whenever an arming attempt fails.
// - Ready output is on only while all inputs and troubles are closed.
// - With retrigger set, each further bell alarm reloads the bell timer.
`default_nettype none
module asop_pulser
  import asop_pkg::*;
#(
  parameter int TICK_CYCLES = ASOP_TICK_CYCLES,
  parameter int NUM_OUT = ASOP_NUM_OUT,
  parameter int TIME_W = ASOP_TIME_W,
  parameter int BELL_W = 16
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ev_alarm,
  input wire logic alarm_bell_en,
  input wire logic alarm_retrigger,
  input wire logic [BELL_W-1:0] bell_time_ticks,
  input wire logic ev_tamper,
  input wire logic ev_exit_start,
  input wire logic ev_entry_start,
  input wire logic ev_arm_done,
  input wire logic ev_disarm_done,
  input wire logic ev_disarm_24hr_done,
  input wire logic ev_arm_start,
  input wire logic ev_arm_fail,
  input wire logic ev_defer_start,
  input wire logic ev_defer_cancel,
  input wire logic ev_count_zero,
  input wire logic ev_count_max,
  input wire logic ev_count_clear,
  input wire logic any_bypassed,
  input wire logic all_closed,
  input wire logic [NUM_OUT*TIME_W-1:0] on_time,
  input wire logic [NUM_OUT*TIME_W-1:0] off_time,
  output logic [NUM_OUT-1:0] out_drive,
  output logic [NUM_OUT-1:0] out_active
);

  logic [31:0] tick_cnt_ff;
  logic tick_ff;
  logic [BELL_W-1:0] bell_cnt_ff;
  logic [NUM_OUT-1:0] act_ff;
  logic [NUM_OUT-1:0] set_ev;
  logic [NUM_OUT-1:0] clr_ev;
  logic bell_expire;

  // The 100 ms enable pulse shared by bell timer and all pulse timers.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt_ff <= 32'h00000000;
      tick_ff <= 1'b0;
    end
    else if (tick_cnt_ff >= 32'(TICK_CYCLES - 1))
    begin
      tick_cnt_ff <= 32'h00000000;
      tick_ff <= 1'b1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
      tick_ff <= 1'b0;
    end
  end

  // Bell timer loads on first bell alarm, reloads on retrigger, stops on disarm.
  // A start that wins over a clear in the same cycle loads a fresh bell time.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      bell_cnt_ff <= '0;
    else if (set_ev[ASOP_O_BELL] && (!act_ff[ASOP_O_BELL] || alarm_retrigger ||
             clr_ev[ASOP_O_BELL]))
      bell_cnt_ff <= bell_time_ticks;
    else if (ev_disarm_done)
      bell_cnt_ff <= '0;
    else if (tick_ff && bell_cnt_ff != '0)
      bell_cnt_ff <= bell_cnt_ff - BELL_W'(1);
  end

  // The bell times out as its counter reaches zero on a tick.
  assign bell_expire = act_ff[ASOP_O_BELL] && tick_ff && bell_cnt_ff <= BELL_W'(1);

  // Set and clear events for each indication except ready; a set in the same cycle wins.
  always_comb
  begin
    set_ev = '0;
    clr_ev = '0;
    set_ev[ASOP_O_BELL] = ev_alarm && alarm_bell_en && bell_time_ticks != '0;
    clr_ev[ASOP_O_BELL] = bell_expire || ev_disarm_done;
    set_ev[ASOP_O_EXIT] = ev_exit_start;
    clr_ev[ASOP_O_EXIT] = ev_arm_done || ev_alarm || ev_disarm_done;
    set_ev[ASOP_O_ENTRY] = ev_entry_start;
    clr_ev[ASOP_O_ENTRY] = ev_disarm_done || ev_alarm;
    set_ev[ASOP_O_DISARMED] = ev_disarm_done;
    clr_ev[ASOP_O_DISARMED] = ev_arm_done;
    set_ev[ASOP_O_ARMED] = ev_arm_done;
    clr_ev[ASOP_O_ARMED] = ev_disarm_done;
    set_ev[ASOP_O_BYPASS] = any_bypassed;
    clr_ev[ASOP_O_BYPASS] = ev_disarm_done;
    set_ev[ASOP_O_TAMPER] = ev_tamper;
    clr_ev[ASOP_O_TAMPER] = ev_disarm_24hr_done;
    set_ev[ASOP_O_MEMORY] = ev_alarm || ev_tamper;
    clr_ev[ASOP_O_MEMORY] = ev_disarm_done;
    set_ev[ASOP_O_COUNT] = ev_count_zero || ev_count_max;
    clr_ev[ASOP_O_COUNT] = ev_count_clear;
    set_ev[ASOP_O_DEFER] = ev_defer_start;
    clr_ev[ASOP_O_DEFER] = ev_arm_start || ev_defer_cancel;
    set_ev[ASOP_O_FAIL] = ev_arm_fail;
    clr_ev[ASOP_O_FAIL] = ev_arm_start || ev_disarm_done;
  end

  // Latched activity; ready alone follows its level directly.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      act_ff <= ASOP_ACT_RST[NUM_OUT-1:0];
    else
    begin
      act_ff <= (act_ff & ~clr_ev) | set_ev;
      act_ff[ASOP_O_READY] <= all_closed;
    end
  end

  assign out_active = act_ff;

  // One cadence timer per indication output.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_pulse
      logic [TIME_W-1:0] t_on;
      logic [TIME_W-1:0] t_off;
      logic [TIME_W-1:0] cnt_ff;
      asop_phase_t ph_ff;
      logic act_d_ff;
      logic steady;
      assign t_on = on_time[gi*TIME_W +: TIME_W];
      assign t_off = off_time[gi*TIME_W +: TIME_W];
      assign steady = (t_on == '0) || (t_off == '0);

      // Phase and count advance on the tick; activation restarts the on phase.
      always_ff @(posedge core_clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          ph_ff <= ASOP_PH_ON;
          cnt_ff <= '0;
          act_d_ff <= 1'b0;
        end
        else
        begin
          act_d_ff <= act_ff[gi];
          if (!act_ff[gi] || !act_d_ff)
          begin
            ph_ff <= ASOP_PH_ON;
            cnt_ff <= '0;
          end
          else if (tick_ff && !steady)
          begin
            case (ph_ff)
              ASOP_PH_ON:
              begin
                if (cnt_ff + TIME_W'(1) >= t_on)
                begin
                  ph_ff <= ASOP_PH_OFF;
                  cnt_ff <= '0;
                end
                else
                  cnt_ff <= cnt_ff + TIME_W'(1);
              end
              default:
              begin
                if (cnt_ff + TIME_W'(1) >= t_off)
                begin
                  ph_ff <= ASOP_PH_ON;
                  cnt_ff <= '0;
                end
                else
                  cnt_ff <= cnt_ff + TIME_W'(1);
              end
            endcase
          end
        end
      end

      // Drive is on during on phase or steadily; off at once when inactive.
      assign out_drive[gi] = act_ff[gi] && (steady || ph_ff == ASOP_PH_ON);
    end
  endgenerate

  // Named steps: a disarm that freshly lights the disarmed output, and a cadence edge.
  sequence s_disarm_fresh;
    ev_disarm_done && !act_ff[ASOP_O_DISARMED];
  endsequence

  sequence s_disarmed_lit;
    act_ff[ASOP_O_DISARMED] && out_drive[ASOP_O_DISARMED];
  endsequence

  sequence s_cadence_edge;
    act_ff[ASOP_O_DISARMED] && $past(act_ff[ASOP_O_DISARMED]) &&
      $changed(out_drive[ASOP_O_DISARMED]) && $stable(on_time) && $stable(off_time);
  endsequence

  // Latch and drive behaviour of the indications; a set in the same cycle as a clear wins.
  AST_ARMED_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
    ev_arm_done |=> act_ff[ASOP_O_ARMED])
    else $error("Armed output not set after arming.");
  AST_DISARMED_CLR: assert property (@(posedge core_clk) disable iff (sys_rst)
    ev_arm_done && !ev_disarm_done |=> !act_ff[ASOP_O_DISARMED])
    else $error("Disarmed output not cleared by arming.");
  AST_BELL_GATE: assert property (@(posedge core_clk) disable iff (sys_rst)
    !act_ff[ASOP_O_BELL] && !(ev_alarm && alarm_bell_en) |=> !act_ff[ASOP_O_BELL])
    else $error("Bell started without a bell alarm.");
  AST_BELL_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    ev_disarm_done && !ev_alarm |=> !act_ff[ASOP_O_BELL] && bell_cnt_ff == '0)
    else $error("Bell kept going after disarm.");
  AST_EXIT_CLR: assert property (@(posedge core_clk) disable iff (sys_rst)
    act_ff[ASOP_O_EXIT] && ev_alarm && !ev_exit_start |=> !act_ff[ASOP_O_EXIT])
    else $error("Exit output not cleared by alarm.");
  AST_MEMORY_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    act_ff[ASOP_O_MEMORY] && !ev_disarm_done |=> act_ff[ASOP_O_MEMORY])
    else $error("Alarm memory dropped without disarm.");
  AST_TAMPER_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    act_ff[ASOP_O_TAMPER] && !ev_disarm_24hr_done |=> act_ff[ASOP_O_TAMPER])
    else $error("Tamper output dropped early.");
  AST_READY: assert property (@(posedge core_clk) disable iff (sys_rst)
    all_closed |=> out_active[ASOP_O_READY])
    else $error("Ready output does not follow closed inputs.");
  AST_DROP_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    !out_active[ASOP_O_ARMED] |-> !out_drive[ASOP_O_ARMED])
    else $error("Inactive output still driven.");
  AST_STEADY: assert property (@(posedge core_clk) disable iff (sys_rst)
    act_ff[ASOP_O_ARMED] && on_time[ASOP_O_ARMED*TIME_W +: TIME_W] == '0
    |-> out_drive[ASOP_O_ARMED])
    else $error("Zero on time did not give steady output.");
  AST_DEFER_CLR: assert property (@(posedge core_clk) disable iff (sys_rst)
    ev_defer_cancel && !ev_defer_start |=> !act_ff[ASOP_O_DEFER])
    else $error("Defer output not cleared by cancel.");
  AST_FAIL_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
    ev_arm_fail |=> act_ff[ASOP_O_FAIL])
    else $error("Fail-to-arm output not set.");

  // Further set and clear events of the latched indications and of ready.
  AST_EXIT_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
    ev_exit_start |=> act_ff[ASOP_O_EXIT])
    else $error("Exit output not set by exit delay start.");
  AST_ENTRY_CLR: assert property (@(posedge core_clk) disable iff (sys_rst)
    act_ff[ASOP_O_ENTRY] && ev_disarm_done && !ev_entry_start |=> !act_ff[ASOP_O_ENTRY])
    else $error("Entry output not cleared by disarm.");
  AST_BYPASS_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
    any_bypassed |=> out_active[ASOP_O_BYPASS])
    else $error("Bypass output off while an input is bypassed.");
  AST_TAMPER_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
    ev_tamper |=> act_ff[ASOP_O_TAMPER])
    else $error("Tamper output not set by tamper alarm.");
  AST_COUNT_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
    ev_count_zero || ev_count_max |=> act_ff[ASOP_O_COUNT])
    else $error("Count output not set at count limit.");
  AST_DEFER_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
    ev_defer_start |=> act_ff[ASOP_O_DEFER])
    else $error("Defer output not set by defer warning.");
  AST_FAIL_CLR: assert property (@(posedge core_clk) disable iff (sys_rst)
    ev_arm_start && !ev_arm_fail |=> !act_ff[ASOP_O_FAIL])
    else $error("Fail-to-arm output not cleared by arming start.");
  AST_READY_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
    !all_closed |=> !out_active[ASOP_O_READY])
    else $error("Ready output stayed on with an open input.");

  // Bell timer reload and expiry.
  AST_BELL_RELOAD: assert property (@(posedge core_clk) disable iff (sys_rst)
    ev_alarm && alarm_bell_en && alarm_retrigger && bell_time_ticks != '0
    |=> bell_cnt_ff == $past(bell_time_ticks))
    else $error("Retriggered alarm did not reload the bell timer.");
  AST_BELL_EXPIRE: assert property (@(posedge core_clk) disable iff (sys_rst)
    act_ff[ASOP_O_BELL] && tick_ff && bell_cnt_ff == BELL_W'(1) && !ev_alarm
    |=> !act_ff[ASOP_O_BELL])
    else $error("Bell stayed on after its timer ran out.");

  // Cadence: a fresh activation starts lit, and the drive only toggles on a tick.
  AST_DISARMED_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_disarm_fresh |=> s_disarmed_lit)
    else $error("Disarmed output not lit after disarming.");
  AST_CADENCE_TICK: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cadence_edge |-> $past(tick_ff))
    else $error("Pulsed output changed phase off the time base tick.");

endmodule
`default_nettype wire

/* tb/asop_area_model.sv */
// Purpose: Area logic stand-in that issues one-cycle area event pulses.
// Assumes: Requests arrive as an event index with a valid flag.
// Notes: One event per cycle, so no single event both sets and clears one output.
`default_nettype none
module asop_area_model
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic req_vld,
  input wire logic [3:0] req_ev,
  output logic [13:0] ev_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each request becomes a pulse that lasts exactly one clock.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ev_ff <= 14'h0000;
    else
      ev_ff <= req_vld ? 14'h0001 << req_ev : 14'h0000;
  end
endmodule
`default_nettype wire

/* tb/asop_pulser_tb.sv */
// Purpose: Self-checking bench for the area status output pulser.
// Assumes: A shortened tick of 10 clocks stands for 100 ms.
// Notes: A reference function tracks every output through random events.
`default_nettype none
module asop_pulser_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, sys_rst = 1'b1, req_vld = 1'b0, bell_en = 1'b0;
  logic retrig = 1'b0, byp = 1'b0, closed = 1'b0;
  logic [3:0] req_ev = 4'h0;
  logic [13:0] ev;
  logic [15:0] bell_t = 16'hFFFF, lfsr = 16'h11A4;
  logic [95:0] on_t = 96'h0, off_t = 96'h0;
  logic [11:0] drive, act, exp_act = 12'h008;
  int miscompares = 0, checks_done = 0, cyc = 0;
  asop_area_model asop_area_model_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .req_vld(req_vld), .req_ev(req_ev), .ev_ff(ev));
  asop_pulser #(.TICK_CYCLES(10)) asop_pulser_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .ev_alarm(ev[0]), .alarm_bell_en(bell_en), .alarm_retrigger(retrig),
    .bell_time_ticks(bell_t), .ev_tamper(ev[1]), .ev_exit_start(ev[2]),
    .ev_entry_start(ev[3]), .ev_arm_done(ev[4]), .ev_disarm_done(ev[5]),
    .ev_disarm_24hr_done(ev[6]), .ev_arm_start(ev[7]), .ev_arm_fail(ev[8]),
    .ev_defer_start(ev[9]), .ev_defer_cancel(ev[10]), .ev_count_zero(ev[11]),
    .ev_count_max(ev[12]), .ev_count_clear(ev[13]), .any_bypassed(byp),
    .all_closed(closed), .on_time(on_t), .off_time(off_t), .out_drive(drive),
    .out_active(act));
  // Clock of 40 ns and a hang guard.
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected activity after event k, with the level inputs now applied.
  function automatic logic [11:0] nxt_exp(logic [11:0] e, logic [3:0] k);
    logic [11:0] n;
    n = e;
    case (k)
      4'h0: n = (n & ~12'h006) | 12'h080 | (bell_en ? 12'h001 : 12'h000);
      4'h1: n = n | 12'h0C0;
      4'h2: n = n | 12'h002;
      4'h3: n = n | 12'h004;
      4'h4: n = (n & ~12'h00A) | 12'h010;
      4'h5: n = (n & ~12'h4B7) | 12'h008;
      4'h6: n = n & ~12'h040;
      4'h7: n = n & ~12'h600;
      4'h8: n = n | 12'h400;
      4'h9: n = n | 12'h200;
      4'hA: n = n & ~12'h200;
      4'hB, 4'hC: n = n | 12'h100;
      4'hD: n = n & ~12'h100;
      default: n = e;
    endcase
    n[5] = n[5] | byp;
    n[11] = closed;
    return n;
  endfunction
  // One event with levels {bell_en, byp, closed}, then compare the activity of all outputs.
  task automatic step(input logic [3:0] k, input logic [2:0] lv);
    @(posedge core_clk);
    req_vld <= 1'b1;
    req_ev <= k;
    {bell_en, byp, closed} <= lv;
    @(posedge core_clk);
    req_vld <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    exp_act = nxt_exp(exp_act, k);
    check({10'h0, act[5:0]}, {10'h0, exp_act[5:0]});
    check({10'h0, act[11:6]}, {10'h0, exp_act[11:6]});
  endtask
  // Re-activate the disarmed output with new cadence times and count on cycles.
  task automatic pulse(input logic [7:0] on, input logic [7:0] off);
    int w;
    int n;
    step(4'h4, 3'b000);
    @(posedge core_clk);
    on_t[31:24] <= on;
    off_t[31:24] <= off;
    step(4'h5, 3'b000);
    w = (on == 0 || off == 0) ? 100 : 20 * (on + off);
    n = 0;
    repeat (10 * on + 20) @(negedge core_clk);
    repeat (w)
    begin
      @(negedge core_clk);
      n += drive[3];
    end
    check(16'(n), 16'((on == 0 || off == 0) ? w : 20 * on));
  endtask
  // Outputs with zero times follow activity; none drives while inactive.
  always @(negedge core_clk)
  begin
    if (!sys_rst)
      check({4'h0, (drive & ~act) | ((drive ^ act) & 12'hFF7)}, 16'h0000);
  end
  initial
  begin
    repeat (15) @(negedge core_clk);
    check({4'h0, act}, 16'h0008);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (60)
    begin
      lfsr = lfsr_next(lfsr);
      step(4'(lfsr[3:0] % 14), lfsr[6:4]);
    end
    @(posedge core_clk);
    bell_t <= 16'h0003;
    // A second alarm reloads the bell only when retrigger is set.
    for (int r = 0; r < 2; r++)
    begin
      @(posedge core_clk);
      retrig <= 1'(r);
      step(4'h5, 3'b000);
      step(4'h0, 3'b100);
      repeat (12) @(negedge core_clk);
      step(4'h0, 3'b100);
      repeat (18) @(negedge core_clk);
      check({15'h0, act[0]}, {15'h0, 1'(r)});
      repeat (20) @(negedge core_clk);
      check({15'h0, act[0]}, 16'h0000);
      exp_act[0] = 1'b0;
    end
    pulse(8'h02, 8'h03);
    pulse(8'hFF, 8'h00);
    pulse(8'h00, 8'h07);
    pulse(8'hFF, 8'h01);
    lfsr = lfsr_next(lfsr);
    pulse(8'(lfsr[1:0] + 1), 8'(lfsr[3:2] + 1));
    test_done();
  end
endmodule
`default_nettype wire
